//--- src/sep_fifo.sv
// Synchronous FIFO of flip-flops with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ps
module sep_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;

    assign inReady = (wp_r - rp_r) != (AW+1)'(DEPTH);
    assign outValid = wp_r != rp_r;
    assign outData = mem_r[rp_r[AW-1:0]];

    always_comb begin
        wp_nxt = wp_r + (AW+1)'(inValid && inReady);
        rp_nxt = rp_r + (AW+1)'(outValid && outReady);
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (inValid && inReady) begin
            mem_r[wp_r[AW-1:0]] <= inData;
        end
    end
endmodule // sep_fifo

//--- src/sep_pkg.sv
// Package for the serial EEPROM pin interface: constants, types, states.
// Assumes a core clock mclk at 40 MHz and a serial clock from the master.
//
// Behaviour
// RL1: Selected only while chip select low; serial input ignored when high.
// RL2: Serial output is high impedance while deselected.
// RL3: Master drops chip select before any sequence; device waits for it.
// RL4: Read bits are shifted onto serial output after serial clock falls.
// RL5: Every input bit is sampled on the rising serial clock edge.
// RL6: Master sets input for rising edges, captures output after falling.
// RL7: Instruction, address and write data all arrive on one input line.
// RL8: Write-protect high permits all reads and writes, status included.
// RL9: Protect low with enable bit one inhibits status register writes.
// RL10: Protect falling while selected aborts the pending status write.
// RL11: Once the write cycle starts, protect falling has no effect.
// RL12: Enable bit zero ignores the protect pin; one enables its functions.
// RL13: Array is 65,536 bytes addressed by a 16-bit byte address.
// RL14: Host drives protect and hold to valid levels, never floating.
// RL15: Hold low suspends input processing and keeps sequence state.
package sep_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam int WEN_BIT = 7;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // Shortened self-timed cycle, in ns, converted to core clocks; real part needs ms.
    localparam int WC_NS = 5000;
    localparam int CLK_NS = 25;
    localparam int WC_CYC = WC_NS / CLK_NS;

    typedef enum logic [2:0] {
        SEP_CMD = 3'h0,
        SEP_ADH = 3'h1,
        SEP_ADL = 3'h2,
        SEP_DATA = 3'h3,
        SEP_STAT = 3'h4,
        SEP_IGN = 3'h5
    } sep_state_e;

    typedef struct packed {
        logic isStatus;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } sep_wr_s;
endpackage

//--- src/sep_top.sv
// Serial EEPROM slave: link logic on the serial clock, storage on mclk.
// Assumes the master drives chip select, hold and protect to valid levels.
`timescale 1ns/1ps
module sep_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic sck,
    input wire logic csn,
    input wire logic si,
    output logic so,
    output logic soOe,
    input wire logic wpn,
    input wire logic holdn,
    output logic writeBusy,
    output logic [sep_pkg::DATA_W-1:0] statusReg
);
    import sep_pkg::*;

    // =====================================================================
    // Link domain: command decode, clocked by the serial clock.
    // =====================================================================
    // Chip select high resets the frame, so no edge outside one matters.
    logic frameRstn;
    assign frameRstn = rstn & ~csn; // [RL1] [RL3]

    sep_state_e st_r, st_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic isRead_r, isRead_nxt;
    logic evTog_r, evTog_nxt;
    sep_wr_s wr_r, wr_nxt;
    logic [7:0] byteIn;
    assign byteIn = {sh_r[6:0], si};

    logic [DATA_W-1:0] rdByte; // from mclk array; stable while read runs
    logic [7:0] outSh_r, outSh_nxt;

    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        addr_nxt = addr_r;
        isRead_nxt = isRead_r;
        evTog_nxt = evTog_r;
        wr_nxt = wr_r;
        if (holdn) begin // [RL15]
            sh_nxt = byteIn; // [RL5] [RL7]
            bit_nxt = bit_r + 3'd1;
            if (bit_r == 3'd7) begin
                unique case (st_r)
                    SEP_CMD: begin
                        isRead_nxt = byteIn == OP_READ;
                        if (byteIn == OP_READ || byteIn == OP_WRITE) begin
                            st_nxt = SEP_ADH;
                        end else if (byteIn == OP_WRSR) begin
                            st_nxt = SEP_STAT;
                        end else begin
                            st_nxt = SEP_IGN;
                        end
                    end
                    SEP_ADH: begin
                        addr_nxt = {byteIn, addr_r[7:0]}; // [RL13]
                        st_nxt = SEP_ADL;
                    end
                    SEP_ADL: begin
                        addr_nxt = {addr_r[15:8], byteIn};
                        st_nxt = SEP_DATA;
                    end
                    SEP_DATA: begin
                        if (!isRead_r) begin
                            wr_nxt = '{isStatus: 1'b0, addr: addr_r,
                                       data: byteIn};
                            evTog_nxt = ~evTog_r;
                        end
                        addr_nxt = addr_r + 16'h0001;
                    end
                    SEP_STAT: begin
                        wr_nxt = '{isStatus: 1'b1, addr: addr_r,
                                   data: byteIn};
                        evTog_nxt = ~evTog_r;
                        st_nxt = SEP_IGN;
                    end
                    SEP_IGN: begin
                        st_nxt = SEP_IGN;
                    end
                    default: st_nxt = SEP_IGN;
                endcase
            end
        end
    end

    always_ff @(posedge sck or negedge frameRstn) begin
        if (!frameRstn) begin
            st_r <= SEP_CMD;
            bit_r <= 3'd0;
            sh_r <= 8'h00;
            addr_r <= 16'h0000;
            isRead_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            addr_r <= addr_nxt;
            isRead_r <= isRead_nxt;
        end
    end

    // Toggle and payload survive deselection so mclk can pick them up.
    always_ff @(posedge sck or negedge rstn) begin
        if (!rstn) begin
            evTog_r <= 1'b0;
            wr_r <= '0;
        end else begin
            evTog_r <= evTog_nxt;
            wr_r <= wr_nxt;
        end
    end

    // Output shifts on the falling edge, loaded at each byte boundary.
    always_comb begin
        outSh_nxt = outSh_r;
        if (holdn) begin
            if (bit_r == 3'd0) begin
                outSh_nxt = rdByte; // [RL4]
            end else begin
                outSh_nxt = {outSh_r[6:0], 1'b0};
            end
        end
    end

    always_ff @(negedge sck or negedge frameRstn) begin
        if (!frameRstn) begin
            outSh_r <= 8'h00;
        end else begin
            outSh_r <= outSh_nxt; // [RL4] [RL6]
        end
    end

    assign so = outSh_r[7];
    // High impedance when deselected, on hold, or outside read data.
    assign soOe = !csn && holdn && isRead_r && st_r == SEP_DATA; // [RL2]

    // =====================================================================
    // Core domain: synchronisers, write queue, array and status register.
    // =====================================================================
    logic tg1_r, tg2_r, tg3_r, cs1_r, cs2_r, wp1_r, wp2_r;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            {tg1_r, tg2_r, tg3_r} <= 3'b000;
            {cs1_r, cs2_r, wp1_r, wp2_r} <= 4'b1111;
        end else begin
            tg1_r <= evTog_r;
            tg2_r <= tg1_r;
            tg3_r <= tg2_r;
            cs1_r <= csn;
            cs2_r <= cs1_r;
            wp1_r <= wpn;
            wp2_r <= wp1_r;
        end
    end

    logic newWr, qInReady, qValid, qReady;
    sep_wr_s qOut;
    assign newWr = tg2_r ^ tg3_r;

    sep_fifo #(.WIDTH($bits(sep_wr_s)), .DEPTH(FIFO_DEPTH)) uFifo (
        .mclk(mclk),
        .rstn(rstn),
        .inValid(newWr),
        .inReady(qInReady),
        .inData(wr_r),
        .outValid(qValid),
        .outReady(qReady),
        .outData(qOut)
    );

    // Writes commit only after chip select rises; each takes WC_CYC clocks.
    logic [DATA_W-1:0] mem_r [2**ADDR_W];
    logic [15:0] wc_r, wc_nxt;
    logic [7:0] stat_r, stat_nxt;
    logic abort_r, abort_nxt;
    logic protect;
    // Pin acts only when the protect enable bit is one.
    assign protect = stat_r[WEN_BIT] && !wp2_r; // [RL9] [RL12] [RL8]
    assign qReady = qValid && cs2_r && wc_r == 16'h0000;
    assign writeBusy = wc_r != 16'h0000;
    assign statusReg = stat_r;
    assign rdByte = mem_r[addr_r];

    always_comb begin
        wc_nxt = wc_r;
        stat_nxt = stat_r;
        abort_nxt = abort_r;
        if (wc_r != 16'h0000) begin
            wc_nxt = wc_r - 16'h0001; // [RL11]
        end
        // Protect active while still selected kills the pending status write.
        if (!cs2_r && protect) begin
            abort_nxt = 1'b1; // [RL10]
        end else if (cs2_r && !qValid) begin
            abort_nxt = 1'b0;
        end
        if (qReady) begin
            if (!qOut.isStatus) begin
                wc_nxt = 16'(WC_CYC);
            end else if (!protect && !abort_r) begin
                stat_nxt = qOut.data; // [RL9] [RL10]
                wc_nxt = 16'(WC_CYC);
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wc_r <= 16'h0000;
            stat_r <= STATUS_RST;
            abort_r <= 1'b0;
        end else begin
            wc_r <= wc_nxt;
            stat_r <= stat_nxt;
            abort_r <= abort_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (qReady && !qOut.isStatus) begin
            mem_r[qOut.addr] <= qOut.data;
        end
    end

    // =====================================================================
    // Checks on the serial output enable and the core-domain write path.
    // =====================================================================
    a_so_tristate: assert property ( // [RL2]
        @(posedge mclk) disable iff (!rstn)
        csn |-> !soOe)
        else $error("serial output driven while idle");
    a_wc_count: assert property ( // [RL11]
        @(posedge mclk) disable iff (!rstn)
        qReady && !qOut.isStatus |=> wc_r == 16'(WC_CYC))
        else $error("write cycle not started");
    a_stat_protect: assert property ( // [RL9]
        @(posedge mclk) disable iff (!rstn)
        protect && !qReady |=> stat_r == $past(stat_r))
        else $error("status changed while protected");
    // A full queue would silently lose a write, so room must always exist.
    a_fifo_room: assert property ( // [RL7]
        @(posedge mclk) disable iff (!rstn)
        newWr |-> qInReady)
        else $error("write queue overflow");
    a_abort_set: assert property ( // [RL10]
        @(posedge mclk) disable iff (!rstn)
        !cs2_r && protect |=> abort_r)
        else $error("protect fall in frame not latched");
    a_stat_drop: assert property ( // [RL9]
        @(posedge mclk) disable iff (!rstn)
        qReady && qOut.isStatus && (protect || abort_r)
        |=> stat_r == $past(stat_r))
        else $error("blocked status write took effect");
    a_stat_commit: assert property ( // [RL12]
        @(posedge mclk) disable iff (!rstn)
        qReady && qOut.isStatus && !protect && !abort_r
        |=> stat_r == $past(qOut.data))
        else $error("permitted status write lost");
endmodule // sep_top

//--- tb/sep_spi_master.sv
// Bus master model for the serial link, mode 0, clock idle low.
// Assumes the testbench calls one task at a time.
`timescale 1ns/1ps
module sep_spi_master (
    output logic sck,
    output logic csn,
    output logic si,
    input wire logic so
);
    localparam int HALF = 32;
    initial begin
        sck = 1'b0;
        csn = 1'b1;
        si = 1'b0;
    end
    // ==========
    // Transfers
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            #HALF sck = 1'b1;
            rx = {rx[6:0], so};
            #HALF sck = 1'b0;
        end
    endtask
    task automatic start();
        csn = 1'b0;
        #HALF;
    endtask
    task automatic stop();
        #HALF csn = 1'b1;
        // Released line flips, so stale data cannot pass for a match.
        si = ~si;
        #(4*HALF);
    endtask
endmodule // sep_spi_master

//--- tb/tb_sep_top.sv
// Testbench for the serial EEPROM slave, link driven by a master model.
// Assumes the package constants and a 64 ns serial clock.
`timescale 1ns/1ps
module tb_sep_top;
    import sep_pkg::*;
    logic mclk, rstn, sck, csn, si, so, soOe, wpn, holdn, writeBusy;
    logic [7:0] statusReg, rx;
    wire soLine;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    int busyRun = 0;
    int busyLen = 0;
    assign soLine = soOe ? so : 1'bz;
    sep_spi_master m (.sck(sck), .csn(csn), .si(si), .so(soLine));
    sep_top dut (.mclk(mclk), .rstn(rstn), .sck(sck), .csn(csn), .si(si),
        .so(so), .soOe(soOe), .wpn(wpn), .holdn(holdn),
        .writeBusy(writeBusy), .statusReg(statusReg));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // ==========
    // Helpers
    task automatic end_sim();
        $display("errors=%0d checked=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Busy starts before a frame's stop returns, so length is timed here.
    always @(posedge mclk) begin
        cyc++;
        if (writeBusy === 1'b1) begin
            busyRun++;
        end else if (busyRun != 0) begin
            busyLen = busyRun;
            busyRun = 0;
        end
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    // Busy must last the shortened write cycle, give or take one clock.
    task automatic settle(input logic busyExp, input logic dropWp);
        int n;
        logic ok;
        n = 0;
        for (int i = 0; i < 20 && writeBusy !== 1'b1; i++) tick();
        ok = writeBusy === 1'b1;
        if (ok && dropWp) wpn = 1'b0;
        while (writeBusy === 1'b1 && n < 400) begin
            tick();
            n++;
        end
        repeat (5) tick();
        chk({7'h0, ok && busyLen >= WC_CYC - 1 && busyLen <= WC_CYC + 1},
            {7'h0, busyExp});
    endtask
    task automatic wrsr(input logic [7:0] v);
        m.start();
        m.xfer(OP_WRSR, rx);
        m.xfer(v, rx);
        m.stop();
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        m.start();
        m.xfer(OP_WRITE, rx);
        m.xfer(a[15:8], rx);
        m.xfer(a[7:0], rx);
        m.xfer(d, rx);
        m.stop();
    endtask
    // ==========
    // Scenarios
    task automatic t_array();
        chk({soOe, writeBusy, 6'h0}, 8'h00);
        chk(statusReg, STATUS_RST);
        wr(16'hffff, 8'ha5);
        settle(1'b1, 1'b0);
        // Hold in mid-frame: the junk byte clocked meanwhile must vanish.
        m.start();
        m.xfer(OP_WRITE, rx);
        holdn = 1'b0;
        m.xfer(8'hff, rx);
        holdn = 1'b1;
        m.xfer(8'h00, rx);
        m.xfer(8'h00, rx);
        m.xfer(8'h3c, rx);
        m.stop();
        settle(1'b1, 1'b0);
        // Deselected traffic must not start a write.
        m.xfer(OP_WRITE, rx);
        m.xfer(8'hff, rx);
        m.xfer(8'hff, rx);
        m.xfer(8'h00, rx);
        settle(1'b0, 1'b0);
        m.start();
        m.xfer(OP_READ, rx);
        m.xfer(8'hff, rx);
        m.xfer(8'hff, rx);
        m.xfer(8'h00, rx);
        chk(rx, 8'ha5);
        chk({7'h0, soOe}, 8'h01);
        m.xfer(8'h00, rx);
        chk(rx, 8'h3c);
        m.stop();
        chk({7'h0, soOe}, 8'h00);
    endtask
    task automatic t_protect();
        wrsr(8'h80);
        settle(1'b1, 1'b0);
        chk(statusReg, 8'h80);
        wpn = 1'b0;
        wrsr(8'h00);
        settle(1'b0, 1'b0);
        chk(statusReg, 8'h80);
        wpn = 1'b1;
        m.start();
        m.xfer(OP_WRSR, rx);
        tick();
        wpn = 1'b0;
        m.xfer(8'h84, rx);
        // Protect is back high before deselect: only the abort can drop it.
        wpn = 1'b1;
        m.stop();
        settle(1'b0, 1'b0);
        wpn = 1'b1;
        chk(statusReg, 8'h80);
        wrsr(8'h00);
        settle(1'b1, 1'b0);
        wpn = 1'b0;
        wrsr(8'h08);
        settle(1'b1, 1'b0);
        chk(statusReg, 8'h08);
        wpn = 1'b1;
        wrsr(8'h84);
        settle(1'b1, 1'b1);
        chk(statusReg, 8'h84);
        wpn = 1'b1;
    endtask
    initial begin
        rstn = 1'b0;
        wpn = 1'b1;
        holdn = 1'b1;
        repeat (5) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (3) tick();
        t_array();
        t_protect();
        end_sim();
    end
endmodule // tb_sep_top
